// ==== hdl/ict_pkg.sv ====
// Shared types and timing figures for the instruction cycle sequencer.
// Assumes one processor clock; all figures are whole clock periods.
package ict_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int CLK_W = 9;             // Total clock count width
  localparam int BUS_W = 4;             // Bus cycle count width
  localparam int SLOT_W = 2;            // Index bits inside one bus cycle
  localparam int OPND_W = 16;           // Source operand width
  localparam int SHCNT_W = 6;           // Shift count width
  localparam int ONES_W = 5;            // Bit count width for multiply

  // Clocks taken by one bus read or write
  localparam logic [CLK_W-1:0] BUS_CLK = 9'h004;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ict_add, ict_sub, ict_and, ict_or, ict_compare_op, ict_exclusive_or,
    ict_signed_divide, ict_unsigned_divide, ict_signed_multiply,
    ict_unsigned_multiply, ict_imm_alu, ict_compare_immediate,
    ict_quick_arith, ict_move_quick, ict_clear_group, ict_decimal_invert,
    ict_test_and_set, ict_test_op, ict_set_on_condition, ict_shift_rotate,
    ict_bit_change_set, ict_bit_clear_op, ict_bit_test_op,
    ict_conditional_branch, ict_unconditional_jump_rel,
    ict_branch_to_subroutine, ict_decrement_loop_branch
  } ict_op_t;

  typedef enum logic [1:0] {ict_byte, ict_word, ict_long} ict_size_t;
  typedef enum logic [1:0] {ict_to_data, ict_to_addr, ict_to_mem} ict_dest_t;
  typedef enum logic {ict_idle, ict_run} ict_state_t;
  typedef enum logic [1:0] {ict_ph_idle, ict_ph_read, ict_ph_internal,
                            ict_ph_write} ict_phase_t;

  // Clocks with bus reads and writes
  typedef struct packed {
    logic [CLK_W-1:0] clk;
    logic [BUS_W-1:0] rd;
    logic [BUS_W-1:0] wr;
  } ict_fig_t;

  // ---------------------------------------------------------------
  // Base figures
  // ---------------------------------------------------------------
  localparam ict_fig_t F_R4   = '{9'h004, 4'h1, 4'h0};
  localparam ict_fig_t F_R6   = '{9'h006, 4'h1, 4'h0};
  localparam ict_fig_t F_R8   = '{9'h008, 4'h1, 4'h0};
  localparam ict_fig_t F_R10  = '{9'h00a, 4'h1, 4'h0};
  localparam ict_fig_t F_M8   = '{9'h008, 4'h1, 4'h1};
  localparam ict_fig_t F_M10  = '{9'h00a, 4'h1, 4'h1};
  localparam ict_fig_t F_M12  = '{9'h00c, 4'h1, 4'h2};
  localparam ict_fig_t F_I8   = '{9'h008, 4'h2, 4'h0};
  localparam ict_fig_t F_I10  = '{9'h00a, 4'h2, 4'h0};
  localparam ict_fig_t F_I12  = '{9'h00c, 4'h2, 4'h0};
  localparam ict_fig_t F_I12L = '{9'h00c, 4'h3, 4'h0};
  localparam ict_fig_t F_I14  = '{9'h00e, 4'h3, 4'h0};
  localparam ict_fig_t F_I16  = '{9'h010, 4'h3, 4'h0};
  localparam ict_fig_t F_IM12 = '{9'h00c, 4'h2, 4'h1};
  localparam ict_fig_t F_IM20 = '{9'h014, 4'h3, 4'h2};
  localparam ict_fig_t F_BSR  = '{9'h012, 4'h2, 4'h2};
  localparam ict_fig_t F_MUL  = '{9'h026, 4'h1, 4'h0};
  localparam ict_fig_t F_SIGNED_DIVIDE = '{9'h09e, 4'h1, 4'h0};
  localparam ict_fig_t F_UNSIGNED_DIVIDE = '{9'h08c, 4'h1, 4'h0};
  localparam ict_fig_t F_STAT = '{9'h004, 4'h1, 4'h0};
  localparam logic [CLK_W-1:0] T_MUL_MAX = 9'h046;

endpackage : ict_pkg

// ==== hdl/ict_seq.sv ====
// Instruction cycle sequencer: works out the clock and bus figures of one
// instruction and paces it: reads first, internal time, writes last.
// Assumes the decode logic on the same clock presents a request with start.
// How it works
// - Address-calculation figures add to base totals
// - Two-operand ops: register 4, memory 8/12
// - Long register ops rise to six clocks, or eight from a direct source
// - Address-slot arithmetic 8 (long 6, or 8 from a direct source), address compare 6
// - Exclusive-or register form needs data-register source
// - Multiply takes 38 plus 2n clocks
// - Signed multiply counts bit transitions over 17 bits
// - Divides take 158 or 140 clocks
// - Immediate forms include literal fetch time
// - Quick address forms, quick move, immediate compare
// - Single-operand clear, invert, test, set timings
// - Shifts take 6/8 plus 2n clocks
// - Bit ops: dynamic maxima, static adds 4(1/0)
// - Branch taken, not taken, subroutine timings
// - Decrement-loop branch: true, looping, expired
`timescale 1ns/1ps
`default_nettype none
module ict_seq (
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic                      start,
  input  wire ict_pkg::ict_op_t          op,
  input  wire ict_pkg::ict_size_t        size,
  input  wire ict_pkg::ict_dest_t        dest,
  input  wire logic                      src_direct,
  input  wire logic                      src_data_reg,
  input  wire logic                      use_ea,
  input  wire logic [8:0]                ea_clk,
  input  wire logic [3:0]                ea_rd,
  input  wire logic [3:0]                ea_wr,
  input  wire logic [15:0]               operand,
  input  wire logic [5:0]                shift_cnt,
  input  wire logic                      cond_true,
  input  wire logic                      disp_word,
  input  wire logic                      loop_expired,
  input  wire logic                      bit_static,
  output logic                           busy,
  output logic                           done,
  output logic                           reject,
  output logic                           bus_rd_go,
  output logic                           bus_wr_go,
  output ict_pkg::ict_phase_t            phase,
  output logic [8:0]                     tot_clk,
  output logic [3:0]                     tot_rd,
  output logic [3:0]                     tot_wr
);
  import ict_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ict_state_t       st;       // Idle or running
    ict_phase_t       ph;       // Bus phase of this clock
    logic [CLK_W-1:0] idx;      // Clock index inside the instruction
    logic [CLK_W-1:0] tclk;     // Total clocks
    logic [BUS_W-1:0] trd;      // Total reads
    logic [BUS_W-1:0] twr;      // Total writes
    logic [CLK_W-1:0] rd_end;   // First clock after the reads
    logic [CLK_W-1:0] wr_beg;   // First clock of the writes
    logic             busy;
    logic             done;
    logic             rej;
    logic             rd_go;
    logic             wr_go;
  } ict_seq_st_t;

  ict_seq_st_t s_reg;           // Registered state
  ict_seq_st_t s_next;          // Next state
  ict_fig_t    fig;             // Base figure of the request
  ict_fig_t    tot;             // Base plus address figure
  logic        legal;           // Request form exists
  logic [ONES_W-1:0] n_ones;    // Multiply n
  logic [OPND_W-1:0] pair_x;    // Bit pairs that differ
  logic [CLK_W-1:0]  bus_clks;  // Clocks taken by bus cycles
  logic [CLK_W-1:0]  wr_off;    // Clock offset inside the writes
  logic        is_long;
  logic        long_boost;

  // Zero below the LSB makes the 17-bit value; each differing pair counts
  assign pair_x = operand ^ {operand[OPND_W-2:0], 1'b0};
  assign is_long = (size == ict_long);
  // Long ALU into a register from a direct or immediate source
  assign long_boost = is_long && src_direct;

  // ---------------------------------------------------------------
  // Multiply n
  // ---------------------------------------------------------------
  // Ones of the source, or transitions for the signed form
  always_comb begin
    n_ones = '0;
    for (int i = 0; i < OPND_W; i++) begin
      if (op == ict_signed_multiply) begin
        n_ones = n_ones + ONES_W'(pair_x[i]);
      end else begin
        n_ones = n_ones + ONES_W'(operand[i]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Base figure
  // ---------------------------------------------------------------
  // Table lookup by class, size and destination
  always_comb begin
    fig = F_R4;
    legal = 1'b1;
    case (op)
      ict_add, ict_sub, ict_and, ict_or: begin
        if (dest == ict_to_mem) begin
          fig = is_long ? F_M12 : F_M8;
        end else if (dest == ict_to_addr) begin
          legal = (op == ict_add) || (op == ict_sub);
          fig = is_long ? (src_direct ? F_R8 : F_R6) : F_R8;
        end else if (is_long) begin
          fig = long_boost ? F_R8 : F_R6;
        end else begin
          fig = F_R4;
        end
      end
      ict_compare_op: begin
        legal = (dest != ict_to_mem);
        fig = (dest == ict_to_addr || is_long) ? F_R6 : F_R4;
      end
      ict_exclusive_or: begin
        if (dest == ict_to_mem) begin
          fig = is_long ? F_M12 : F_M8;
        end else begin
          legal = (dest == ict_to_data) && src_data_reg;
          fig = is_long ? F_R8 : F_R4;
        end
      end
      ict_signed_divide, ict_unsigned_divide: begin
        legal = (dest == ict_to_data);
        fig = (op == ict_signed_divide) ? F_SIGNED_DIVIDE : F_UNSIGNED_DIVIDE;
      end
      ict_signed_multiply, ict_unsigned_multiply: begin
        legal = (dest == ict_to_data);
        fig = F_MUL;
        fig.clk = F_MUL.clk + {3'h0, n_ones, 1'b0};
      end
      ict_imm_alu: begin
        legal = (dest != ict_to_addr);
        if (dest == ict_to_mem) begin
          fig = is_long ? F_IM20 : F_IM12;
        end else begin
          fig = is_long ? F_I16 : F_I8;
        end
      end
      ict_compare_immediate: begin
        legal = (dest != ict_to_addr);
        if (dest == ict_to_mem) begin
          fig = is_long ? F_I12L : F_I8;
        end else begin
          fig = is_long ? F_I14 : F_I8;
        end
      end
      ict_quick_arith: begin
        if (dest == ict_to_addr) begin
          legal = (size != ict_byte);
          fig = F_R8;
        end else if (dest == ict_to_mem) begin
          fig = is_long ? F_M12 : F_M8;
        end else begin
          fig = is_long ? F_R8 : F_R4;
        end
      end
      ict_move_quick: begin
        legal = is_long && (dest == ict_to_data);
        fig = F_R4;
      end
      ict_clear_group: begin
        legal = (dest != ict_to_addr);
        if (dest == ict_to_mem) begin
          fig = is_long ? F_M12 : F_M8;
        end else begin
          fig = is_long ? F_R6 : F_R4;
        end
      end
      ict_decimal_invert: begin
        legal = (dest != ict_to_addr);
        fig = (dest == ict_to_mem) ? F_M8 : F_R6;
      end
      ict_test_and_set: begin
        legal = (dest != ict_to_addr);
        fig = (dest == ict_to_mem) ? F_M10 : F_R4;
      end
      ict_test_op: begin
        fig = F_R4;
      end
      ict_set_on_condition: begin
        legal = (dest != ict_to_addr);
        if (dest == ict_to_mem) begin
          fig = F_M8;
        end else begin
          fig = cond_true ? F_R6 : F_R4;
        end
      end
      ict_shift_rotate: begin
        if (dest == ict_to_mem) begin
          legal = !is_long;
          fig = F_M8;
        end else begin
          legal = (dest == ict_to_data);
          fig = is_long ? F_R8 : F_R6;
          fig.clk = fig.clk + {2'h0, shift_cnt, 1'b0};
        end
      end
      ict_bit_change_set, ict_bit_clear_op, ict_bit_test_op: begin
        legal = (dest != ict_to_addr);
        if (dest == ict_to_mem) begin
          fig = (op == ict_bit_test_op) ? F_R4 : F_M8;
        end else if (op == ict_bit_clear_op) begin
          fig = F_R10;
        end else begin
          fig = (op == ict_bit_test_op) ? F_R6 : F_R8;
        end
        if (bit_static) begin
          fig.clk = fig.clk + F_STAT.clk;
          fig.rd = fig.rd + F_STAT.rd;
        end
      end
      ict_conditional_branch: begin
        if (cond_true) begin
          fig = F_I10;
        end else begin
          fig = disp_word ? F_I12 : F_R8;
        end
      end
      ict_unconditional_jump_rel: begin
        fig = F_I10;
      end
      ict_branch_to_subroutine: begin
        fig = F_BSR;
      end
      ict_decrement_loop_branch: begin
        if (cond_true) begin
          fig = F_I12;
        end else begin
          fig = loop_expired ? F_I14 : F_I10;
        end
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Totals and sequencing
  // ---------------------------------------------------------------
  // Adds address figures, then paces reads, internal time and writes
  always_comb begin
    tot = fig;
    if (use_ea) begin
      tot.clk = fig.clk + ea_clk;
      tot.rd = fig.rd + ea_rd;
      tot.wr = fig.wr + ea_wr;
    end
    bus_clks = CLK_W'(tot.rd + tot.wr) * BUS_CLK;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rej = 1'b0;
    s_next.rd_go = 1'b0;
    s_next.wr_go = 1'b0;
    s_next.ph = ict_ph_idle;
    case (s_reg.st)
      ict_idle: begin
        if (start) begin
          // Forms that do not exist, or too short for their bus cycles
          if (legal && (bus_clks <= tot.clk)) begin
            s_next.st = ict_run;
            s_next.idx = '0;
            s_next.tclk = tot.clk;
            s_next.trd = tot.rd;
            s_next.twr = tot.wr;
            s_next.rd_end = CLK_W'(tot.rd) * BUS_CLK;
            s_next.wr_beg = tot.clk - CLK_W'(tot.wr) * BUS_CLK;
          end else begin
            s_next.rej = 1'b1;
          end
        end
      end
      ict_run: begin
        if (s_reg.idx == s_reg.tclk - BUS_CLK / BUS_CLK) begin
          s_next.st = ict_idle;
        end else begin
          s_next.idx = s_reg.idx + BUS_CLK / BUS_CLK;
        end
      end
      default: begin
        s_next.st = ict_idle;
      end
    endcase
    wr_off = s_next.idx - s_next.wr_beg;
    s_next.busy = (s_next.st == ict_run);
    if (s_next.busy) begin
      // Reads open the instruction, writes close it, internal between
      if (s_next.idx < s_next.rd_end) begin
        s_next.ph = ict_ph_read;
        s_next.rd_go = (s_next.idx[SLOT_W-1:0] == '0);
      end else if (s_next.idx >= s_next.wr_beg) begin
        s_next.ph = ict_ph_write;
        s_next.wr_go = (wr_off[SLOT_W-1:0] == '0);
      end else begin
        s_next.ph = ict_ph_internal;
      end
      s_next.done = (s_next.idx == s_next.tclk - BUS_CLK / BUS_CLK);
    end
  end

  // Registers the whole state
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign reject = s_reg.rej;
  assign bus_rd_go = s_reg.rd_go;
  assign bus_wr_go = s_reg.wr_go;
  assign phase = s_reg.ph;
  assign tot_clk = s_reg.tclk;
  assign tot_rd = s_reg.trd;
  assign tot_wr = s_reg.twr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [CLK_W-1:0] chk_clks;   // Busy clocks before this one
  logic [BUS_W-1:0] chk_rds;    // Read starts before this one
  logic [BUS_W-1:0] chk_wrs;    // Write starts before this one
  logic             accept;     // Request taken this clock

  assign accept = start && !s_reg.busy && legal && (bus_clks <= tot.clk);

  // Counts what the sequencer really did during a run
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chk_clks <= '0;
      chk_rds <= '0;
      chk_wrs <= '0;
    end else if (!busy) begin
      chk_clks <= '0;
      chk_rds <= '0;
      chk_wrs <= '0;
    end else begin
      chk_clks <= chk_clks + CLK_W'(1);
      chk_rds <= chk_rds + BUS_W'(bus_rd_go);
      chk_wrs <= chk_wrs + BUS_W'(bus_wr_go);
    end
  end

  sequence seq_bus_slot(go);
    go ##1 !go [*3];
  endsequence

  chk_total_clocks: assert property (done |-> chk_clks == tot_clk - 9'h001)
    else $error("run length differs from total clocks");
  chk_read_count: assert property (done |-> chk_rds + BUS_W'(bus_rd_go) == tot_rd)
    else $error("read starts differ from read total");
  chk_write_count: assert property (done |-> chk_wrs + BUS_W'(bus_wr_go) == tot_wr)
    else $error("write starts differ from write total");
  chk_read_slot: assert property (bus_rd_go |-> seq_bus_slot(bus_rd_go))
    else $error("read cycle shorter than four clocks");
  chk_internal_quiet: assert property (phase == ict_ph_internal
    |-> !bus_rd_go && !bus_wr_go)
    else $error("bus access during internal time");
  chk_mul_bound: assert property (accept && !use_ea && op == ict_unsigned_multiply
                                  |=> tot_clk <= T_MUL_MAX)
    else $error("multiply beyond its maximum");
  chk_divide_fig: assert property (accept && !use_ea && op == ict_signed_divide
                                   |=> tot_clk == F_SIGNED_DIVIDE.clk && tot_rd == F_SIGNED_DIVIDE.rd)
    else $error("signed divide figure wrong");
  chk_eor_source: assert property (start && !busy && op == ict_exclusive_or
                                   && dest == ict_to_data && !src_data_reg
                                   |=> reject && !busy)
    else $error("exclusive-or accepted a bad source");
  chk_loop_expire: assert property (accept && !use_ea && op == ict_decrement_loop_branch
                                    && !cond_true && loop_expired
                                    |=> tot_clk == F_I14.clk && tot_rd == F_I14.rd)
    else $error("expired loop figure wrong");

endmodule : ict_seq
`default_nettype wire

// ==== sim/ict_bus_model.sv ====
// Bus-side model: memory and peripherals that see each bus cycle start.
// Assumes the sequencer's clock; clr restarts the tallies for a new request.
`timescale 1ns/1ps
`default_nettype none
module ict_bus_model (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                clr,
  input  wire logic                bus_rd_go,
  input  wire logic                bus_wr_go,
  input  wire ict_pkg::ict_phase_t phase,
  output logic [3:0]               n_rd,
  output logic [3:0]               n_wr,
  output logic [8:0]               n_int,
  output logic                     bad
);
  import ict_pkg::*;
  // ---------------------------------------------------------------
  // Bus cycle tracking
  // ---------------------------------------------------------------
  logic [1:0] left_reg;  // Clocks left in the open bus cycle

  // Tally starts and internal clocks; flag overlapped or mislabelled cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {n_rd, n_wr, n_int, bad, left_reg} <= '0;
    end else if (clr) begin
      {n_rd, n_wr, n_int, bad, left_reg} <= '0;
    end else begin
      if (bus_rd_go || bus_wr_go) begin
        // A new cycle may only open once four clocks have gone by
        if (left_reg != 2'h0) bad <= 1'b1;
        if (bus_rd_go && phase != ict_ph_read) bad <= 1'b1;
        if (bus_wr_go && phase != ict_ph_write) bad <= 1'b1;
        n_rd <= n_rd + {3'h0, bus_rd_go};
        n_wr <= n_wr + {3'h0, bus_wr_go};
        left_reg <= 2'h3;
      end else if (left_reg != 2'h0) begin
        // Inside a bus cycle the core is neither idle nor internal
        if (phase == ict_ph_internal || phase == ict_ph_idle) bad <= 1'b1;
        left_reg <= left_reg - 2'h1;
      end
      // Internal clocks carry no bus access
      if (phase == ict_ph_internal) n_int <= n_int + 9'h001;
    end
  end
endmodule : ict_bus_model
`default_nettype wire

// ==== sim/instruction_cycle_timing_tb_top.sv ====
// Self-checking bench for the instruction cycle sequencer.
// Assumes ict_seq and the bus model share one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_tb_top;
  import ict_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct packed {
    ict_op_t     op;
    ict_size_t   sz;
    ict_dest_t   dst;
    logic [6:0]  f;   // Source, ea, condition, displacement, expiry, static
    logic [15:0] v;   // Operand; low bits also give the shift count
    logic [8:0]  c;
    logic [3:0]  r;
    logic [3:0]  w;
  } ict_row_t;
  ict_row_t    q[$];                        // Ordinary cases
  logic        ref_clk, nrst, start, clr;   // Clock, reset, strobes
  logic        src_direct, src_data_reg, use_ea, cond_true;
  logic        disp_word, loop_expired, bit_static;
  ict_op_t     op;
  ict_size_t   size;
  ict_dest_t   dest;
  logic [8:0]  ea_clk, tot_clk, n_int;
  logic [3:0]  ea_rd, ea_wr, tot_rd, tot_wr, n_rd, n_wr;
  logic [15:0] operand;
  logic [5:0]  shift_cnt;
  logic        busy, done, reject, bus_rd_go, bus_wr_go, bad;
  ict_phase_t  phase;
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;

  ict_seq ict_seq_i (.ref_clk, .nrst, .start, .op, .size, .dest, .src_direct,
    .src_data_reg, .use_ea, .ea_clk, .ea_rd, .ea_wr, .operand, .shift_cnt,
    .cond_true, .disp_word, .loop_expired, .bit_static, .busy, .done, .reject,
    .bus_rd_go, .bus_wr_go, .phase, .tot_clk, .tot_rd, .tot_wr);
  ict_bus_model ict_bus_model_i (.ref_clk, .nrst, .clr, .bus_rd_go, .bus_wr_go,
    .phase, .n_rd, .n_wr, .n_int, .bad);

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  // Cut a hang short well past the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Compare a count
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Compare a flag
  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk1

  task automatic add(input ict_op_t o, input ict_size_t s, input ict_dest_t d,
                     input logic [6:0] f, input logic [15:0] v,
                     input logic [8:0] c, input logic [3:0] r, input logic [3:0] w);
    q.push_back('{o, s, d, f, v, c, r, w});
  endtask : add

  // Present one request for one cycle; bus tallies restart with it
  task automatic go(input ict_row_t x);
    @(posedge ref_clk);
    start <= 1'b1;
    clr <= 1'b1;
    op <= x.op;
    size <= x.sz;
    dest <= x.dst;
    {src_direct, src_data_reg, use_ea, cond_true, disp_word, loop_expired,
     bit_static} <= x.f;
    operand <= x.v;
    shift_cnt <= x.v[5:0];
    @(posedge ref_clk);
    start <= 1'b0;
    clr <= 1'b0;
  endtask : go

  // Run one accepted request and check totals, duration and bus use
  task automatic run(input ict_row_t x);
    int k;
    go(x);
    k = 1;
    #1;
    while (done !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk(9'(k), x.c);
    chk(tot_clk, x.c);
    chk({5'h00, tot_rd}, {5'h00, x.r});
    chk({5'h00, tot_wr}, {5'h00, x.w});
    @(posedge ref_clk);
    #1;
    chk1(busy, 1'b0);
    chk({5'h00, n_rd}, {5'h00, x.r});
    chk({5'h00, n_wr}, {5'h00, x.w});
    chk(n_int, x.c - {3'h0, x.r + x.w, 2'h0});
    chk1(bad, 1'b0);
  endtask : run

  // Illegal form: one reject pulse, nothing runs
  task automatic rej(input ict_op_t o, input ict_size_t s, input ict_dest_t d,
                     input logic [6:0] f);
    go('{o, s, d, f, 16'h0000, 9'h000, 4'h0, 4'h0});
    #1;
    chk1(reject, 1'b1);
    chk1(busy, 1'b0);
    @(posedge ref_clk);
    #1;
    chk1(reject, 1'b0);
  endtask : rej

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {ref_clk, nrst, start, clr, src_direct, src_data_reg, use_ea} = '0;
    {cond_true, disp_word, loop_expired, bit_static} = '0;
    op = ict_add;
    size = ict_byte;
    dest = ict_to_data;
    operand = 16'h0000;
    shift_cnt = 6'h00;
    ea_clk = 9'h004;   // Address calculation worth 4(1/0)
    ea_rd = 4'h1;
    ea_wr = 4'h0;
    add(ict_add,ict_word,ict_to_data,7'h00,16'h0000,9'h004,4'h1,4'h0);
    add(ict_add,ict_long,ict_to_mem,7'h00,16'h0000,9'h00c,4'h1,4'h2);
    add(ict_add,ict_long,ict_to_data,7'h40,16'h0000,9'h008,4'h1,4'h0);
    add(ict_or,ict_long,ict_to_data,7'h10,16'h0000,9'h00a,4'h2,4'h0);
    add(ict_sub,ict_word,ict_to_addr,7'h00,16'h0000,9'h008,4'h1,4'h0);
    add(ict_compare_op,ict_byte,ict_to_addr,7'h00,16'h0000,9'h006,4'h1,4'h0);
    add(ict_exclusive_or,ict_long,ict_to_data,7'h20,16'h0000,9'h008,4'h1,4'h0);
    add(ict_unsigned_multiply,ict_word,ict_to_data,7'h00,16'hffff,9'h046,4'h1,4'h0);
    add(ict_unsigned_multiply,ict_word,ict_to_data,7'h00,16'h0000,9'h026,4'h1,4'h0);
    add(ict_signed_multiply,ict_word,ict_to_data,7'h00,16'h5555,9'h046,4'h1,4'h0);
    add(ict_signed_multiply,ict_word,ict_to_data,7'h00,16'h0001,9'h02a,4'h1,4'h0);
    add(ict_signed_divide,ict_word,ict_to_data,7'h00,16'h0000,9'h09e,4'h1,4'h0);
    add(ict_unsigned_divide,ict_word,ict_to_data,7'h00,16'h0000,9'h08c,4'h1,4'h0);
    add(ict_imm_alu,ict_long,ict_to_data,7'h00,16'h0000,9'h010,4'h3,4'h0);
    add(ict_quick_arith,ict_byte,ict_to_data,7'h00,16'h0000,9'h004,4'h1,4'h0);
    add(ict_quick_arith,ict_long,ict_to_addr,7'h00,16'h0000,9'h008,4'h1,4'h0);
    add(ict_move_quick,ict_long,ict_to_data,7'h00,16'h0000,9'h004,4'h1,4'h0);
    add(ict_compare_immediate,ict_long,ict_to_mem,7'h00,16'h0000,9'h00c,4'h3,4'h0);
    add(ict_test_and_set,ict_byte,ict_to_mem,7'h00,16'h0000,9'h00a,4'h1,4'h1);
    add(ict_set_on_condition,ict_byte,ict_to_data,7'h08,16'h0000,9'h006,4'h1,4'h0);
    add(ict_set_on_condition,ict_byte,ict_to_data,7'h00,16'h0000,9'h004,4'h1,4'h0);
    add(ict_shift_rotate,ict_long,ict_to_data,7'h00,16'h0005,9'h012,4'h1,4'h0);
    add(ict_shift_rotate,ict_word,ict_to_mem,7'h00,16'h0000,9'h008,4'h1,4'h1);
    add(ict_bit_clear_op,ict_long,ict_to_data,7'h01,16'h0000,9'h00e,4'h2,4'h0);
    add(ict_bit_change_set,ict_byte,ict_to_mem,7'h01,16'h0000,9'h00c,4'h2,4'h1);
    add(ict_conditional_branch,ict_word,ict_to_data,7'h04,16'h0000,9'h00c,4'h2,4'h0);
    add(ict_conditional_branch,ict_byte,ict_to_data,7'h00,16'h0000,9'h008,4'h1,4'h0);
    add(ict_branch_to_subroutine,ict_word,ict_to_data,7'h08,16'h0000,9'h012,4'h2,4'h2);
    add(ict_decrement_loop_branch,ict_word,ict_to_data,7'h08,16'h0000,9'h00c,4'h2,4'h0);
    add(ict_decrement_loop_branch,ict_word,ict_to_data,7'h02,16'h0000,9'h00e,4'h3,4'h0);
    add(ict_and,ict_long,ict_to_data,7'h00,16'h0000,9'h006,4'h1,4'h0);
    add(ict_clear_group,ict_long,ict_to_data,7'h00,16'h0000,9'h006,4'h1,4'h0);
    add(ict_decimal_invert,ict_byte,ict_to_data,7'h00,16'h0000,9'h006,4'h1,4'h0);
    add(ict_test_op,ict_word,ict_to_mem,7'h00,16'h0000,9'h004,4'h1,4'h0);
    add(ict_unconditional_jump_rel,ict_word,ict_to_data,7'h00,16'h0000,9'h00a,4'h2,4'h0);
    add(ict_bit_test_op,ict_byte,ict_to_mem,7'h01,16'h0000,9'h008,4'h2,4'h0);
    // Reset: outputs quiet while held
    @(posedge ref_clk);
    #1;
    chk1(busy, 1'b0);
    chk(tot_clk, 9'h000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (q[i]) run(q[i]);
    // Refused forms
    rej(ict_exclusive_or, ict_word, ict_to_data, 7'h00);
    rej(ict_quick_arith, ict_byte, ict_to_addr, 7'h00);
    rej(ict_move_quick, ict_word, ict_to_data, 7'h00);
    rej(ict_shift_rotate, ict_long, ict_to_mem, 7'h00);
    // Start while busy is ignored, then reset in mid-run
    go(q[11]);
    repeat (5) @(posedge ref_clk);
    start <= 1'b1;
    op <= ict_test_op;
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    chk(tot_clk, 9'h09e);
    @(posedge ref_clk);
    nrst <= 1'b0;
    #1;
    chk1(busy, 1'b0);
    chk1(bus_rd_go, 1'b0);
    chk(tot_clk, 9'h000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    run(q[1]);
    tally_and_finish();
  end
endmodule : instruction_cycle_timing_tb_top
`default_nettype wire
